// ==== rtl/get_epoch_timebase.sv ====
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module get_epoch_timebase #(
    parameter int unsigned TICK_DIV = get_pkg::OSC_HZ / get_pkg::TICK_HZ
) (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins and supplies
    input  wire logic        external_event_input,
    input  wire logic        core_supply_ok,
    input  wire logic        io_supply_ok,
    // Timing outputs
    output logic             ref_tick,
    output logic             meas_strobe,
    output logic             nav_epoch,
    output logic             time_pulse_output,
    // Power outputs
    output logic             core_supply_off,
    output logic             rtc_osc_run,
    output logic             battery_backed_memory_hold
);
    import get_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] ms_to_us(input logic [31:0] ms);
        ms_to_us = 32'(ms * US_PER_MS);
    endfunction

    function automatic logic [2:0] utc_pick(input logic [2:0] sel,
                                            input logic [3:0] en);
        if (sel != UTC_AUTO)
            utc_pick = sel;
        else if (en[0])
            utc_pick = UTC_USNO;
        else if (en[1])
            utc_pick = UTC_SU;
        else if (en[2])
            utc_pick = UTC_NTSC;
        else if (en[3])
            utc_pick = UTC_EUROPE;
        else
            utc_pick = UTC_NONE;
    endfunction

    typedef enum logic [2:0] {
        PWR_RUN     = 3'b001,
        PWR_STANDBY = 3'b010,
        PWR_BACKUP  = 3'b100
    } get_pwr_t;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] s1_q, s2_q, s3_q, pin_q;
    wire  [2:0] pin_raw = {io_supply_ok, core_supply_ok,
                           external_event_input};
    wire  [2:0] pin_agree = ~(s2_q ^ s3_q);
    wire  [2:0] pin_d = (pin_agree & s3_q) | (~pin_agree & pin_q);
    wire        evt_rise = pin_d[0] & ~pin_q[0];
    wire        supplies_gone = ~pin_d[1] & ~pin_d[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= 3'h6;
            s2_q  <= 3'h6;
            s3_q  <= 3'h6;
            pin_q <= 3'h6;
        end else if (clk_en) begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    get_ctrl_t   ctrl_q;
    get_status_t status;
    get_pwr_t    pwr_q;
    logic [31:0] local_ms_q, sol_us_q, bias_q, drift_q, conv_gps_q;
    logic [31:0] gps_ms_q, utc_ms_q, evt_ms_q, epoch_local_q;
    logic [15:0] period_q, interval_q, tick_cnt_q;
    logic [7:0]  leap_q;
    logic [$clog2(TICK_DIV)-1:0] div_q;
    logic gps_cv_q, utc_cv_q, time_valid_q, sol_new_q, pulse_q;

    wire setup    = psel & ~penable;
    wire wr_en    = psel & penable & pwrite & pready;
    wire wr_step  = wr_en & (paddr == ADDR_STEP_MS);
    wire wr_sol   = wr_en & (paddr == ADDR_SOL_US);
    wire wr_conv  = wr_en & (paddr == ADDR_CONV_GPS);
    wire wr_leap  = wr_en & (paddr == ADDR_LEAP_S);
    wire wr_pwr   = wr_en & (paddr == ADDR_PWR_REQ) & pwdata[0];

    logic [31:0] rd_mux;
    logic        hit;
    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADDR_CTRL:     rd_mux = 32'(ctrl_q);
            ADDR_STATUS:   rd_mux = 32'(status);
            ADDR_LOCAL_MS: rd_mux = local_ms_q;
            ADDR_STEP_MS:  rd_mux = 32'h0000_0000;
            ADDR_PERIOD:   rd_mux = {16'h0000, period_q};
            ADDR_SOL_US:   rd_mux = sol_us_q;
            ADDR_BIAS_US:  rd_mux = bias_q;
            ADDR_DRIFT_US: rd_mux = drift_q;
            ADDR_CONV_GPS: rd_mux = conv_gps_q;
            ADDR_LEAP_S:   rd_mux = {24'h00_0000, leap_q};
            ADDR_GPS_MS:   rd_mux = gps_ms_q;
            ADDR_UTC_MS:   rd_mux = utc_ms_q;
            ADDR_EVT_MS:   rd_mux = evt_ms_q;
            ADDR_PWR_REQ:  rd_mux = 32'h0000_0000;
            default:       hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= get_ctrl_t'(CTRL_RESET);
            period_q <= PERIOD_RESET;
        end else if (clk_en && wr_en) begin
            if (paddr == ADDR_CTRL)
                ctrl_q <= get_ctrl_t'(pwdata[CTRL_W-1:0]);
            if (paddr == ADDR_PERIOD && pwdata[15:0] > 16'h0002)
                period_q <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Tick divider and local time
    // ------------------------------------------------------------
    localparam logic [$clog2(TICK_DIV)-1:0] DIV_LAST =
        ($clog2(TICK_DIV))'(TICK_DIV - 1);
    wire running = ctrl_q.run & (pwr_q == PWR_RUN);
    wire tick    = running & (div_q == DIV_LAST);
    wire epoch   = tick & (tick_cnt_q == interval_q - 16'h0001);

    // Nearest tick to the wanted time; a tie keeps the earlier one
    wire signed [31:0] bias_s = $signed(bias_q);
    wire late  = bias_s >= $signed(HALF_TICK_US);
    wire early = bias_s < -$signed(HALF_TICK_US);
    wire [15:0] next_interval = late  ? period_q - 16'h0001 :
                                early ? period_q + 16'h0001 :
                                        period_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q      <= '0;
            tick_cnt_q <= 16'h0000;
            interval_q <= PERIOD_RESET;
            local_ms_q <= 32'h0000_0000;
        end else if (clk_en) begin
            div_q <= (!running || tick) ? '0 : div_q + 1'b1;
            if (wr_step)
                local_ms_q <= pwdata;
            else if (tick)
                local_ms_q <= local_ms_q + 32'h0000_0001;
            if (epoch) begin
                tick_cnt_q <= 16'h0000;
                interval_q <= next_interval;
            end else if (tick) begin
                tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Bias, drift and time conversion
    // ------------------------------------------------------------
    wire [31:0] conv_use = gps_cv_q ? conv_gps_q : DEF_CONV_GPS;
    wire [7:0]  leap_use = utc_cv_q ? leap_q : DEF_LEAP_S;
    wire [31:0] gps_now  = local_ms_q + conv_use;
    wire [31:0] utc_now  = gps_now - 32'({24'h00_0000, leap_use} * MS_PER_S);
    wire [31:0] bias_new = sol_us_q - ms_to_us(epoch_local_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sol_us_q      <= 32'h0000_0000;
            sol_new_q     <= 1'b0;
            bias_q        <= 32'h0000_0000;
            drift_q       <= 32'h0000_0000;
            epoch_local_q <= 32'h0000_0000;
            conv_gps_q    <= 32'h0000_0000;
            leap_q        <= 8'h00;
            gps_cv_q      <= 1'b0;
            utc_cv_q      <= 1'b0;
            time_valid_q  <= 1'b0;
            gps_ms_q      <= 32'h0000_0000;
            utc_ms_q      <= 32'h0000_0000;
        end else if (clk_en) begin
            if (epoch)
                epoch_local_q <= local_ms_q;
            if (wr_sol)
                sol_us_q <= pwdata;
            sol_new_q <= wr_sol;
            if (sol_new_q) begin
                bias_q  <= bias_new;
                drift_q <= bias_new - bias_q;
            end
            if (wr_conv) begin
                conv_gps_q <= pwdata;
                gps_cv_q   <= 1'b1;
            end
            if (wr_leap) begin
                leap_q   <= pwdata[7:0];
                utc_cv_q <= 1'b1;
            end
            if (wr_step)
                time_valid_q <= 1'b1;
            if (epoch) begin
                gps_ms_q <= gps_now;
                utc_ms_q <= utc_now;
            end
        end
    end

    // ------------------------------------------------------------
    // Time pulse and event input
    // ------------------------------------------------------------
    // Grid is independent of gnss_en; no cross-check is made
    wire [2:0] grid     = ctrl_q.pulse_time_grid_select;
    wire [2:0] evt_base = (grid == GRID_UTC) ? GRID_GPS : grid;
    wire       armed    = (grid != GRID_UTC) | utc_cv_q;
    logic [2:0] evt_base_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_q    <= 1'b0;
            evt_ms_q   <= 32'h0000_0000;
            evt_base_q <= GRID_GPS;
        end else if (clk_en) begin
            if (epoch)
                pulse_q <= armed;
            else if (tick)
                pulse_q <= 1'b0;
            if (evt_rise && running) begin
                evt_ms_q   <= local_ms_q;
                evt_base_q <= evt_base;
            end
        end
    end

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= PWR_RUN;
        end else if (clk_en) begin
            unique case (pwr_q)
                PWR_RUN:
                    if (supplies_gone)
                        pwr_q <= PWR_BACKUP;
                    else if (wr_pwr)
                        pwr_q <= PWR_STANDBY;
                PWR_STANDBY:
                    if (supplies_gone)
                        pwr_q <= PWR_BACKUP;
                    else if (evt_rise)
                        pwr_q <= PWR_RUN;
                PWR_BACKUP:
                    if (pin_d[1] && pin_d[2])
                        pwr_q <= PWR_RUN;
                default:
                    pwr_q <= PWR_RUN;
            endcase
        end
    end

    always_comb begin
        status.evt_base       = evt_base_q;
        status.utc_eff        = utc_pick(ctrl_q.utc_variant_select,
                                         ctrl_q.gnss_en);
        status.pwr_state      = pwr_q;
        status.pulse_armed    = armed;
        status.utc_conv_valid = utc_cv_q;
        status.gps_conv_valid = gps_cv_q;
        status.time_valid     = time_valid_q;
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_tick          <= 1'b0;
            meas_strobe       <= 1'b0;
            nav_epoch         <= 1'b0;
            time_pulse_output <= 1'b0;
            core_supply_off   <= 1'b0;
            rtc_osc_run       <= 1'b1;
            battery_backed_memory_hold <= 1'b1;
        end else if (clk_en) begin
            ref_tick          <= tick;
            meas_strobe       <= tick;
            nav_epoch         <= epoch;
            time_pulse_output <= pulse_q;
            core_supply_off   <= (pwr_q != PWR_RUN);
            rtc_osc_run       <= 1'b1;
            battery_backed_memory_hold <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tick_spacing: assert property (tick |=> !tick [*8])
        else $error("tick repeated too soon");
    a_meas_align: assert property (clk_en |=> meas_strobe == ref_tick)
        else $error("measurement strobe off tick");
    a_local_count: assert property (
        clk_en && tick && !wr_step |=> local_ms_q == $past(local_ms_q) + 1)
        else $error("local time did not advance");
    a_step_load: assert property (
        clk_en && wr_step |=> local_ms_q == $past(pwdata) && time_valid_q)
        else $error("local time not stepped");
    a_epoch_tick: assert property (clk_en && epoch |=> nav_epoch && ref_tick)
        else $error("epoch off tick");
    a_interval_band: assert property (clk_en && epoch && !wr_en |=>
        interval_q + 16'h0001 >= period_q && interval_q <= period_q + 16'h0001)
        else $error("interval out of band");
    a_bias_calc: assert property (
        clk_en && sol_new_q |=> bias_q == $past(bias_new))
        else $error("bias not updated");
    a_pulse_gate: assert property (
        time_pulse_output |-> $past(armed, 2) || $past(pulse_q, 2))
        else $error("pulse without conversion data");
    a_auto_utc: assert property (
        ctrl_q.utc_variant_select == UTC_AUTO && ctrl_q.gnss_en[0]
        |-> status.utc_eff == UTC_USNO) else $error("bad utc pick");
    a_backup_entry: assert property (
        clk_en && supplies_gone |=> pwr_q == PWR_BACKUP)
        else $error("backup not entered");
    a_standby_off: assert property (
        clk_en && pwr_q == PWR_STANDBY |=> core_supply_off)
        else $error("core supply left on");

    c_epoch: cover property (nav_epoch);
    c_standby: cover property (pwr_q == PWR_STANDBY);
    c_short_interval: cover property (epoch && late);
    c_event: cover property (evt_rise && running);
endmodule

// ==== shared/get_pkg.sv ====
package get_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_LOCAL_MS = 8'h08;
    localparam logic [7:0] ADDR_STEP_MS  = 8'h0C;
    localparam logic [7:0] ADDR_PERIOD   = 8'h10;
    localparam logic [7:0] ADDR_SOL_US   = 8'h14;
    localparam logic [7:0] ADDR_BIAS_US  = 8'h18;
    localparam logic [7:0] ADDR_DRIFT_US = 8'h1C;
    localparam logic [7:0] ADDR_CONV_GPS = 8'h20;
    localparam logic [7:0] ADDR_LEAP_S   = 8'h24;
    localparam logic [7:0] ADDR_GPS_MS   = 8'h28;
    localparam logic [7:0] ADDR_UTC_MS   = 8'h2C;
    localparam logic [7:0] ADDR_EVT_MS   = 8'h30;
    localparam logic [7:0] ADDR_PWR_REQ  = 8'h34;

    // ------------------------------------------------------------
    // Encodings and defaults
    // ------------------------------------------------------------
    localparam logic [2:0] GRID_UTC = 3'h0;
    localparam logic [2:0] GRID_GPS = 3'h1;
    localparam logic [2:0] UTC_AUTO   = 3'h0;
    localparam logic [2:0] UTC_USNO   = 3'h1;
    localparam logic [2:0] UTC_SU     = 3'h2;
    localparam logic [2:0] UTC_NTSC   = 3'h3;
    localparam logic [2:0] UTC_EUROPE = 3'h4;
    localparam logic [2:0] UTC_NONE   = 3'h7;

    localparam int unsigned OSC_HZ  = 25_000_000;
    localparam int unsigned TICK_HZ = 1_000;
    localparam logic [31:0] US_PER_MS    = 32'h0000_03E8;
    localparam logic [31:0] MS_PER_S     = 32'h0000_03E8;
    localparam logic [15:0] PERIOD_RESET = 16'h03E8;
    localparam logic [31:0] HALF_TICK_US = 32'h0000_01F4;
    localparam logic [31:0] DEF_CONV_GPS = 32'h0000_0000;
    localparam logic [7:0]  DEF_LEAP_S   = 8'h00;

    typedef struct packed {
        logic [3:0] gnss_en;   // gal, bds, glo, gps
        logic [2:0] utc_variant_select;
        logic [2:0] pulse_time_grid_select;
        logic       run;
    } get_ctrl_t;
    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h0F1;

    typedef struct packed {
        logic [2:0] evt_base;
        logic [2:0] utc_eff;
        logic [2:0] pwr_state;
        logic       pulse_armed;
        logic       utc_conv_valid;
        logic       gps_conv_valid;
        logic       time_valid;
    } get_status_t;

endpackage

// ==== verification/get_host_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host processor: APB master for configuration and requests
// ------------------------------------------------------------
module get_host_model (
    // Clock
    input  wire logic        pclk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data must not keep the last value
        pwdata  <= ~d;
    endtask

    task automatic power_request();
        logic [31:0] r;
        logic        e;
        xfer(1'b1, get_pkg::ADDR_PWR_REQ, 32'h0000_0001, r, e);
    endtask
endmodule

// ==== verification/get_epoch_timebase_tb_top.sv ====
`timescale 1ns/100ps
module get_epoch_timebase_tb_top;
    import get_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, ext_evt = 1'b0;
    logic core_ok = 1'b1, io_ok = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, ref_tick, meas_strobe;
    logic nav_epoch, tp_out, core_off, rtc_run, bbm_hold;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, a, v;
    logic [15:0] lfsr = 16'hD7D0;
    logic        e;
    int err_total = 0, n_compared = 0, cycles = 0, n, p;

    always #20 pclk = ~pclk;

    get_epoch_timebase #(.TICK_DIV(10)) i_dut (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_event_input(ext_evt),
        .core_supply_ok(core_ok), .io_supply_ok(io_ok),
        .ref_tick(ref_tick), .meas_strobe(meas_strobe),
        .nav_epoch(nav_epoch), .time_pulse_output(tp_out),
        .core_supply_off(core_off), .rtc_osc_run(rtc_run),
        .battery_backed_memory_hold(bbm_hold));
    get_host_model i_host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [2:0] exp_utc(logic [3:0] en);
        if (en[0]) return UTC_USNO;
        if (en[1]) return UTC_SU;
        if (en[2]) return UTC_NTSC;
        if (en[3]) return UTC_EUROPE;
        return UTC_NONE;
    endfunction
    task automatic check(string nm, logic [31:0] seen, logic [31:0] x);
        n_compared++;
        if (seen !== x) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, seen);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] ad, logic [31:0] d);
        i_host.xfer(1'b1, ad, d, r, e);
    endtask
    task automatic rd(logic [7:0] ad);
        i_host.xfer(1'b0, ad, 32'h0000_0000, r, e);
    endtask
    task automatic wait_sig(ref logic s, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (s !== 1'b1 && n < lim);
    endtask
    task automatic set_ctrl(logic [3:0] en, logic [2:0] u, logic [2:0] g);
        wr(ADDR_CTRL, {21'h0, en, u, g, 1'b1});
    endtask
    task automatic pulse_event();
        @(posedge pclk) ext_evt <= 1'b1;
        repeat (8) @(posedge pclk);
        ext_evt <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL);
        check("ctrl", r, 32'(CTRL_RESET));
        rd(ADDR_PERIOD);
        check("period", r, 32'(PERIOD_RESET));
        rd(ADDR_CONV_GPS);
        check("conv", r, DEF_CONV_GPS);
        rd(ADDR_STATUS);
        check("valid", 32'(r[2:0]), 32'h0);
        check("rtc", 32'(rtc_run & bbm_hold), 32'h1);
        rd(8'h40);
        check("unmapped", {r[30:0], e}, 32'h1);
        wait_sig(ref_tick, 100);
        wait_sig(ref_tick, 100);
        check("tick_div", n, 10);
        check("strobe", 32'(meas_strobe), 32'h1);
        rd(ADDR_LOCAL_MS);
        a = r;
        repeat (5) wait_sig(ref_tick, 100);
        rd(ADDR_LOCAL_MS);
        check("local_ms", r - a, 32'h5);
        lfsr = lfsr_next(lfsr);
        v = {16'h0, lfsr};
        wait_sig(ref_tick, 100);
        wr(ADDR_STEP_MS, v);
        rd(ADDR_LOCAL_MS);
        check("step", r, v);
        rd(ADDR_STATUS);
        check("time_valid", 32'(r[0]), 32'h1);
        for (int g = 0; g < 16; g++) begin
            set_ctrl(4'(g), UTC_AUTO, GRID_UTC);
            rd(ADDR_STATUS);
            check("utc_auto", 32'(r[9:7]), 32'(exp_utc(4'(g))));
        end
        lfsr = lfsr_next(lfsr);
        p = 3 + lfsr[2:0];
        wr(ADDR_PERIOD, p);
        wr(ADDR_PERIOD, 32'h2);
        rd(ADDR_PERIOD);
        check("period_min", r, p);
        set_ctrl(4'h1, UTC_AUTO, GRID_UTC);
        // First epoch still uses the reset interval
        repeat (2) begin
            wait_sig(nav_epoch, 12000);
            check("epoch_tick", 32'(ref_tick), 32'h1);
            repeat (3) @(posedge pclk);
            check("pulse_gated", 32'(tp_out), 32'h0);
        end
        wr(ADDR_LEAP_S, 32'h0000_0012);
        wait_sig(nav_epoch, 2000);
        repeat (3) @(posedge pclk);
        check("pulse_on", 32'(tp_out), 32'h1);
        wait_sig(nav_epoch, 2000);
        repeat (3) begin
            a = 0;
            do begin
                wait_sig(ref_tick, 100);
                a++;
            end while (nav_epoch !== 1'b1 && a < 50);
            check("interval", 32'(a >= p - 1 && a <= p + 1), 1);
        end
        // Solution exactly half a tick late: the earlier tick must win
        rd(ADDR_LOCAL_MS);
        a = r - 1;
        wr(ADDR_SOL_US, a * US_PER_MS + HALF_TICK_US);
        rd(ADDR_BIAS_US);
        check("bias", r, HALF_TICK_US);
        rd(ADDR_DRIFT_US);
        check("drift", r, HALF_TICK_US);
        wait_sig(nav_epoch, 2000);
        a = 0;
        do begin
            wait_sig(ref_tick, 100);
            a++;
        end while (nav_epoch !== 1'b1 && a < 50);
        check("interval_tie", a, p - 1);
        lfsr = lfsr_next(lfsr);
        wr(ADDR_CONV_GPS, {16'h0, lfsr});
        rd(ADDR_STATUS);
        check("gps_conv", 32'(r[1]), 32'h1);
        wait_sig(nav_epoch, 2000);
        rd(ADDR_LOCAL_MS);
        a = r - 1;
        rd(ADDR_GPS_MS);
        check("gps_ms", r, a + {16'h0, lfsr});
        rd(ADDR_UTC_MS);
        check("utc_ms", r, a + {16'h0, lfsr} - 32'h0000_0012 * MS_PER_S);
        for (int g = 0; g < 3; g++) begin
            set_ctrl(4'h1, UTC_USNO, 3'(g));
            pulse_event();
            rd(ADDR_STATUS);
            check("evt_base", 32'(r[12:10]),
                  (g == GRID_UTC) ? 32'(GRID_GPS) : g);
        end
        i_host.power_request();
        repeat (2) @(posedge pclk);
        check("standby", 32'(core_off & rtc_run), 32'h1);
        rd(ADDR_STATUS);
        check("pwr_sb", 32'(r[6:4]), 32'h2);
        pulse_event();
        check("wake", 32'(core_off), 32'h0);
        @(posedge pclk) core_ok <= 1'b0;
        io_ok <= 1'b0;
        repeat (8) @(posedge pclk);
        check("backup", 32'(core_off & bbm_hold), 32'h1);
        core_ok <= 1'b1;
        io_ok <= 1'b1;
        repeat (8) @(posedge pclk);
        check("restore", 32'(core_off), 32'h0);
        give_verdict();
    end
endmodule
